// [pkg/amp_defs.svh]
// Summary of operation
// - Device is only an I2C target; never drives SCL nor starts transfers.
// - Serial clock accepted up to 400 kHz; master must not exceed it.
// - Audio input supports I2S, right, left justified, TDM; 16 to 32 bit words.
// - Audio input sample rates are 44.1, 48 and 96 kHz.
// - Audio port control bits 3 to 5 are ignored unless format is TDM.
// - Writing bit 7 of register 0x21 clears latched faults.
// - Bit 6 of register 0x21 selects frame driving the parallel output.
// - Switching frequency is an integer multiple of sample rate, e.g. 44.
// - Parallel output commands take effect only while in standby.
`ifndef AMP_DEFS_SVH
`define AMP_DEFS_SVH

// ==========================================
// Register map
`define AMP_REG_AUDIO_PORT 8'h03
`define AMP_REG_MISC3 8'h21
`define AMP_REG_FAULT_STATUS 8'h10
`define AMP_AUDIO_PORT_RESET 8'h04
`define AMP_MISC3_RESET 8'h0c

// ==========================================
// Field positions
`define AMP_WLEN_LSB 0
`define AMP_TDM_LSB 3
`define AMP_FMT_LSB 6
`define AMP_RATE_LSB 0
`define AMP_MULT_LSB 2
`define AMP_PAR_BIT 5
`define AMP_FRAME_BIT 6
`define AMP_CLR_BIT 7

// ==========================================
// Bus timing
`define AMP_SCL_MAX_KHZ 400
`define AMP_CLK_MHZ 250
`define AMP_SPIKE_NS 50
`define AMP_SPIKE_CYC ((`AMP_SPIKE_NS * `AMP_CLK_MHZ) / 1000)
`define AMP_I2C_BASE_ADDR 7'h34

`endif

// [pkg/amp_pkg.sv]
package amp_pkg;
  typedef enum logic [1:0] {AMP_FMT_I2S, AMP_FMT_RJ, AMP_FMT_LJ, AMP_FMT_TDM} amp_fmt_t;
  typedef enum logic [1:0] {AMP_FS_44K1, AMP_FS_48K, AMP_FS_96K} amp_rate_t;
  typedef enum {AMP_S_IDLE, AMP_S_ADDR, AMP_S_INDEX, AMP_S_WDATA, AMP_S_ACK_OUT, AMP_S_RDATA,
                AMP_S_ACK_IN} amp_state_t;
  typedef enum {AMP_PH_INDEX, AMP_PH_WRITE, AMP_PH_READ} amp_phase_t;
endpackage : amp_pkg

// [core/amp_pin_filter.sv]
`timescale 1ns/1ps
`include "amp_defs.svh"
module amp_pin_filter #(
  parameter int W = 12
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Pins
  input wire logic [W-1:0] raw,
  output logic [W-1:0] clean
);
  import amp_pkg::*;
  localparam logic [4:0] SPIKE = 5'(`AMP_SPIKE_CYC);

  // ==========================================
  // Two-flop synchroniser and spike filter per pin
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_pin
      logic s1, s2, q;
      logic next_q;
      logic [4:0] cnt, next_cnt;
      always_comb begin
        next_q = q;
        next_cnt = 5'h00;
        if (s2 != q) begin
          // A level must hold past the spike window before it is believed
          next_cnt = cnt + 5'h01;
          if (cnt >= SPIKE) begin
            next_q = s2;
            next_cnt = 5'h00;
          end
        end
      end
      always_ff @(posedge core_clk) begin
        if (rst) begin
          s1 <= 1'b1;
          s2 <= 1'b1;
          q <= 1'b1;
          cnt <= 5'h00;
        end else begin
          s1 <= raw[g];
          s2 <= s1;
          q <= next_q;
          cnt <= next_cnt;
        end
      end
      assign clean[g] = q;
    end
  endgenerate
endmodule : amp_pin_filter

// [core/amp_control_port.sv]
`timescale 1ns/1ps
`include "amp_defs.svh"
module amp_control_port (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // I2C pins; SCL is input only
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Address straps and fault sources
  input wire logic [1:0] addr_sel,
  input wire logic [7:0] fault_in,
  // Amplifier state
  input wire logic amp_standby,
  // Audio port configuration
  output amp_pkg::amp_fmt_t input_format,
  output logic [2:0] word_length,
  output logic [2:0] tdm_slot,
  output amp_pkg::amp_rate_t sample_rate,
  output logic [5:0] pwm_fs_multiple,
  // Output stage control
  output logic parallel_bridge_output,
  output logic frame_select,
  output logic fault_clear
);
  import amp_pkg::*;

  // ==========================================
  // Pin conditioning
  logic [11:0] pins;
  // Fault pins pass inverted: the filter resets to one, which must read as no fault
  amp_pin_filter #(.W(12)) u_filt (
    .core_clk(core_clk),
    .rst(rst),
    .raw({~fault_in, addr_sel, sda_i, scl_i}),
    .clean(pins)
  );
  logic scl, sda, scl_q, sda_q;
  assign scl = pins[0];
  assign sda = pins[1];
  wire start_c = scl && scl_q && sda_q && !sda;
  wire stop_c = scl && scl_q && !sda_q && sda;
  wire scl_rise = scl && !scl_q;
  wire scl_fall = !scl && scl_q;

  // ==========================================
  // Register helpers
  function automatic logic [5:0] mult_decode(input logic [2:0] code);
    case (code)
      3'h0: mult_decode = 6'h08;
      3'h1: mult_decode = 6'h0a;
      3'h2: mult_decode = 6'h26;
      3'h4: mult_decode = 6'h30;
      default: mult_decode = 6'h2c;
    endcase
  endfunction : mult_decode

  // ==========================================
  // Bus state
  amp_state_t st, next_st;
  amp_phase_t ph, next_ph;
  logic [3:0] cnt, next_cnt;
  logic [7:0] sh, next_sh;
  logic [7:0] index, next_index;
  logic nack, next_nack;
  logic oe, next_oe;
  logic [6:0] my_addr, next_my_addr;
  logic wr_en;
  logic [7:0] audio, misc, flt, rd_data;
  logic [7:0] next_audio, next_misc, next_flt;

  always_comb begin
    case (index)
      `AMP_REG_AUDIO_PORT: rd_data = audio;
      `AMP_REG_MISC3: rd_data = misc;
      `AMP_REG_FAULT_STATUS: rd_data = flt;
      default: rd_data = 8'h00;
    endcase
  end

  always_comb begin
    next_st = st;
    next_ph = ph;
    next_cnt = cnt;
    next_sh = sh;
    next_index = index;
    next_nack = nack;
    next_oe = oe;
    next_my_addr = my_addr;
    wr_en = 1'b0;
    // Straps only move while this port is in AMP_S_IDLE so a transfer to it sees one address
    if (st == AMP_S_IDLE) next_my_addr = `AMP_I2C_BASE_ADDR | {5'h00, pins[3:2]};
    if (stop_c) begin
      next_st = AMP_S_IDLE;
      next_oe = 1'b0;
    end else if (start_c) begin
      next_st = AMP_S_ADDR;
      next_cnt = 4'h0;
      next_oe = 1'b0;
    end else begin
      case (st)
        AMP_S_IDLE: next_oe = 1'b0;
        AMP_S_ADDR, AMP_S_INDEX, AMP_S_WDATA: begin
          // 250 MHz sampling leaves ample margin at a 400 kHz bus clock
          if (scl_rise) begin
            next_sh = {sh[6:0], sda};
            next_cnt = cnt + 4'h1;
          end else if (scl_fall && cnt == 4'h8) begin
            next_cnt = 4'h0;
            next_st = AMP_S_ACK_OUT;
            next_oe = 1'b1;
            if (st == AMP_S_ADDR) begin
              if (sh[7:1] != my_addr) begin
                next_st = AMP_S_IDLE;
                next_oe = 1'b0;
              end
              next_ph = sh[0] ? AMP_PH_READ : AMP_PH_INDEX;
            end else if (st == AMP_S_INDEX) begin
              next_index = sh;
              next_ph = AMP_PH_WRITE;
            end else begin
              wr_en = 1'b1;
              next_index = index + 8'h01;
            end
          end
        end
        AMP_S_ACK_OUT: if (scl_fall) begin
          next_oe = 1'b0;
          case (ph)
            AMP_PH_INDEX: next_st = AMP_S_INDEX;
            AMP_PH_WRITE: next_st = AMP_S_WDATA;
            default: begin
              next_st = AMP_S_RDATA;
              next_oe = !rd_data[7];
              next_sh = {rd_data[6:0], 1'b0};
              next_cnt = 4'h1;
              next_index = index + 8'h01;
            end
          endcase
        end
        AMP_S_RDATA: if (scl_fall) begin
          if (cnt == 4'h8) begin
            next_oe = 1'b0;
            next_st = AMP_S_ACK_IN;
          end else begin
            next_oe = !sh[7];
            next_sh = {sh[6:0], 1'b0};
            next_cnt = cnt + 4'h1;
          end
        end
        AMP_S_ACK_IN: begin
          if (scl_rise) next_nack = sda;
          if (scl_fall) begin
            if (nack) begin
              next_st = AMP_S_IDLE;
            end else begin
              next_st = AMP_S_RDATA;
              next_oe = !rd_data[7];
              next_sh = {rd_data[6:0], 1'b0};
              next_cnt = 4'h1;
              next_index = index + 8'h01;
            end
          end
        end
        default: next_st = AMP_S_IDLE;
      endcase
    end
  end

  // ==========================================
  // Control registers and fault latch
  wire clr_req = wr_en && index == `AMP_REG_MISC3 && sh[`AMP_CLR_BIT];
  always_comb begin
    next_audio = audio;
    next_misc = misc;
    if (wr_en && index == `AMP_REG_AUDIO_PORT) next_audio = sh;
    // Clear bit is a command, it never reads back as one
    if (wr_en && index == `AMP_REG_MISC3) next_misc = {1'b0, sh[6:0]};
    // A fault arriving in the clearing cycle stays latched
    next_flt = (clr_req ? 8'h00 : flt) | ~pins[11:4];
  end

  // ==========================================
  // Output decode
  amp_fmt_t next_fmt;
  amp_rate_t next_rate;
  logic [2:0] next_wlen, next_tdm;
  logic next_par;
  always_comb begin
    next_fmt = amp_fmt_t'(audio[`AMP_FMT_LSB +: 2]);
    // Word length codes above 32 bit are held at 32 bit
    next_wlen = audio[`AMP_WLEN_LSB +: 3] > 3'h4 ? 3'h4 : audio[`AMP_WLEN_LSB +: 3];
    next_tdm = next_fmt == AMP_FMT_TDM ? audio[`AMP_TDM_LSB +: 3] : 3'h0;
    case (misc[`AMP_RATE_LSB +: 2])
      2'h0: next_rate = AMP_FS_44K1;
      2'h2: next_rate = AMP_FS_96K;
      default: next_rate = AMP_FS_48K;
    endcase
    // Parallel mode change is frozen outside standby to protect the bridges
    next_par = amp_standby ? misc[`AMP_PAR_BIT] : parallel_bridge_output;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st <= AMP_S_IDLE;
      ph <= AMP_PH_INDEX;
      cnt <= 4'h0;
      sh <= 8'h00;
      index <= 8'h00;
      nack <= 1'b0;
      oe <= 1'b0;
      my_addr <= `AMP_I2C_BASE_ADDR;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      audio <= `AMP_AUDIO_PORT_RESET;
      misc <= `AMP_MISC3_RESET;
      flt <= 8'h00;
      sda_o <= 1'b0;
      sda_oe <= 1'b0;
      input_format <= AMP_FMT_I2S;
      word_length <= 3'h0;
      tdm_slot <= 3'h0;
      sample_rate <= AMP_FS_48K;
      pwm_fs_multiple <= 6'h2c;
      parallel_bridge_output <= 1'b0;
      frame_select <= 1'b0;
      fault_clear <= 1'b0;
    end else begin
      st <= next_st;
      ph <= next_ph;
      cnt <= next_cnt;
      sh <= next_sh;
      index <= next_index;
      nack <= next_nack;
      oe <= next_oe;
      my_addr <= next_my_addr;
      scl_q <= scl;
      sda_q <= sda;
      audio <= next_audio;
      misc <= next_misc;
      flt <= next_flt;
      sda_o <= 1'b0;
      sda_oe <= next_oe;
      input_format <= next_fmt;
      word_length <= next_wlen;
      tdm_slot <= next_tdm;
      sample_rate <= next_rate;
      pwm_fs_multiple <= mult_decode(misc[`AMP_MULT_LSB +: 3]);
      parallel_bridge_output <= next_par;
      frame_select <= misc[`AMP_FRAME_BIT];
      fault_clear <= clr_req;
    end
  end

  // ==========================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  wire [1:0] fmt_raw = audio[`AMP_FMT_LSB +: 2];
  wire frame_raw = misc[`AMP_FRAME_BIT];
  sequence s_clr_write;
    wr_en && index == `AMP_REG_MISC3 && sh[`AMP_CLR_BIT];
  endsequence
  sequence s_clr_pulse;
    fault_clear ##1 !fault_clear;
  endsequence
  property p_oe_addressed;
    sda_oe |-> $past(st) != AMP_S_IDLE;
  endproperty
  a_oe_addressed: assert property (p_oe_addressed) else $error("SDA driven while idle");
  property p_fmt;
    1'b1 |=> input_format == amp_fmt_t'($past(fmt_raw));
  endproperty
  a_fmt: assert property (p_fmt) else $error("Format output lags register");
  property p_wlen;
    word_length <= 3'h4;
  endproperty
  a_wlen: assert property (p_wlen) else $error("Illegal word length");
  property p_rate;
    sample_rate != amp_rate_t'(2'h3);
  endproperty
  a_rate: assert property (p_rate) else $error("Unsupported sample rate");
  property p_tdm_gate;
    fmt_raw != 2'h3 |=> tdm_slot == 3'h0;
  endproperty
  a_tdm_gate: assert property (p_tdm_gate) else $error("Slot bits used outside TDM");
  property p_clear;
    s_clr_write |=> s_clr_pulse;
  endproperty
  a_clear: assert property (p_clear) else $error("Fault clear pulse missing");
  property p_frame;
    1'b1 |=> frame_select == $past(frame_raw);
  endproperty
  a_frame: assert property (p_frame) else $error("Frame select not following register");
  property p_mult;
    pwm_fs_multiple inside {6'h08, 6'h0a, 6'h26, 6'h2c, 6'h30};
  endproperty
  a_mult: assert property (p_mult) else $error("Switching multiple not integer option");
  property p_par_hold;
    !amp_standby |=> $stable(parallel_bridge_output);
  endproperty
  a_par_hold: assert property (p_par_hold) else $error("Parallel mode changed outside standby");
  property p_index;
    wr_en |=> index == $past(index) + 8'h01;
  endproperty
  a_index: assert property (p_index) else $error("Register index not advanced");
endmodule : amp_control_port

// [test/amp_i2c_host_model.sv]
`timescale 1ns/1ps
`include "amp_defs.svh"
module amp_i2c_host_model (
  // Clock
  input wire logic core_clk,
  // Device side of the data line
  input wire logic sda_oe,
  input wire logic sda_o,
  // Bus lines seen by the device
  output logic scl,
  output logic sda
);
  // ==========================================
  // Open-drain data line with pull-up
  logic m_low;
  assign sda = !(m_low || (sda_oe && !sda_o));
  initial begin
    scl = 1'b1;
    m_low = 1'b0;
  end

  // ==========================================
  // Bit timing: 4 quarters of 157 cycles keep SCL just below 400 kHz
  task automatic qtr;
    repeat (157) @(posedge core_clk);
    #1;
  endtask : qtr

  // Only this model moves SCL; the device merely answers
  task automatic bit_io(input logic b, output logic s);
    m_low = !b;
    qtr();
    scl = 1'b1;
    qtr();
    s = sda;
    qtr();
    scl = 1'b0;
    qtr();
  endtask : bit_io

  // Data held from SCL low through the whole high phase, MSB first
  task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
      q[i] = s;
    end
    bit_io(1'b1, s);
    ack = !s;
  endtask : xfer

  // Also serves as repeated start, entered with SCL low
  task automatic start;
    m_low = 1'b0;
    qtr();
    scl = 1'b1;
    qtr();
    m_low = 1'b1;
    qtr();
    scl = 1'b0;
    qtr();
  endtask : start

  task automatic stop;
    m_low = 1'b1;
    qtr();
    scl = 1'b1;
    qtr();
    m_low = 1'b0;
    qtr();
  endtask : stop

  // ==========================================
  // Register accesses
  task automatic write_reg(input logic [6:0] a, input logic [7:0] idx, input logic [7:0] d,
                           output logic [2:0] acks);
    logic [7:0] q;
    start();
    xfer({a, 1'b0}, q, acks[2]);
    xfer(idx, q, acks[1]);
    xfer(d, q, acks[0]);
    stop();
  endtask : write_reg

  // Last byte is answered with a NACK, which ends the read
  task automatic read_reg(input logic [6:0] a, input logic [7:0] idx, output logic [7:0] d,
                          output logic [2:0] acks);
    logic [7:0] q;
    logic ign;
    start();
    xfer({a, 1'b0}, q, acks[2]);
    xfer(idx, q, acks[1]);
    start();
    xfer({a, 1'b1}, q, acks[0]);
    xfer(8'hff, d, ign);
    stop();
  endtask : read_reg
endmodule : amp_i2c_host_model

// [test/testbench.sv]
`timescale 1ns/1ps
`include "amp_defs.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module testbench;
  import amp_pkg::*;
  logic core_clk, rst, scl, sda, sda_o, sda_oe, amp_standby;
  logic parallel_bridge_output, frame_select, fault_clear;
  logic [1:0] addr_sel;
  logic [7:0] fault_in, rd;
  logic [2:0] word_length, tdm_slot, acks;
  logic [5:0] pwm_fs_multiple;
  logic [6:0] dev_addr;
  amp_fmt_t input_format;
  amp_rate_t sample_rate;
  int n_mismatch, n_checks, n_cyc, n_clr;

  // ==========================================
  // Design and bus master
  amp_control_port amp_control_port_i (
    .core_clk(core_clk), .rst(rst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .addr_sel(addr_sel), .fault_in(fault_in), .amp_standby(amp_standby),
    .input_format(input_format), .word_length(word_length), .tdm_slot(tdm_slot),
    .sample_rate(sample_rate), .pwm_fs_multiple(pwm_fs_multiple),
    .parallel_bridge_output(parallel_bridge_output), .frame_select(frame_select),
    .fault_clear(fault_clear)
  );
  amp_i2c_host_model amp_i2c_host_model_i (
    .core_clk(core_clk), .sda_oe(sda_oe), .sda_o(sda_o), .scl(scl), .sda(sda)
  );

  // ==========================================
  // Clock, pulse counter and hang limit
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  initial begin
    n_cyc = 0;
    n_clr = 0;
  end
  always @(posedge core_clk) begin
    n_cyc++;
    if (fault_clear === 1'b1) n_clr++;
    if (n_cyc == 110000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  // ==========================================
  // Bring-up sequence: configure, clear faults, confirm none
  initial begin
    n_mismatch = 0;
    n_checks = 0;
    rst = 1'b1;
    addr_sel = 2'b10;
    fault_in = 8'h00;
    amp_standby = 1'b0;
    repeat (12) @(posedge core_clk);
    #1 rst = 1'b0;
    // Pin filters need time to settle before the first START
    repeat (25) @(posedge core_clk);
    #1;
    `CHK("sda_o", 1'b0, sda_o)
    `CHK("word_length", 3'd4, word_length)
    `CHK("input_format", AMP_FMT_I2S, input_format)
    `CHK("sample_rate", AMP_FS_44K1, sample_rate)
    `CHK("pwm_fs_multiple", 6'd44, pwm_fs_multiple)
    `CHK("tdm_slot", 3'd0, tdm_slot)
    `CHK("parallel", 1'b0, parallel_bridge_output)
    `CHK("sda_oe", 1'b0, sda_oe)
    dev_addr = `AMP_I2C_BASE_ADDR | {5'h00, addr_sel};
    // Slot bits set while the format is not TDM
    amp_i2c_host_model_i.write_reg(dev_addr, `AMP_REG_AUDIO_PORT, 8'h2b, acks);
    `CHK("acks", 3'b111, acks)
    `CHK("tdm_slot", 3'd0, tdm_slot)
    `CHK("word_length", 3'd3, word_length)
    amp_i2c_host_model_i.write_reg(dev_addr, `AMP_REG_AUDIO_PORT, 8'heb, acks);
    `CHK("acks", 3'b111, acks)
    `CHK("input_format", AMP_FMT_TDM, input_format)
    `CHK("tdm_slot", 3'd5, tdm_slot)
    // A fault comes and goes; its indication must stay latched
    fault_in = 8'h04;
    repeat (100) @(posedge core_clk);
    #1 fault_in = 8'h00;
    `CHK("clear pulses", 0, n_clr)
    // The fault capture is long finished before its status is read
    amp_i2c_host_model_i.read_reg(dev_addr, `AMP_REG_FAULT_STATUS, rd, acks);
    `CHK("acks", 3'b111, acks)
    `CHK("fault status", 8'h04, rd)
    // Last setting plus fault clear in one write keeps the run short:
    // rate 96k, multiple 48, parallel request, frame select, outside standby
    amp_i2c_host_model_i.write_reg(dev_addr, `AMP_REG_MISC3, 8'hf2, acks);
    `CHK("acks", 3'b111, acks)
    `CHK("sample_rate", AMP_FS_96K, sample_rate)
    `CHK("pwm_fs_multiple", 6'd48, pwm_fs_multiple)
    `CHK("frame_select", 1'b1, frame_select)
    `CHK("parallel", 1'b0, parallel_bridge_output)
    `CHK("clear pulses", 1, n_clr)
    amp_standby = 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    `CHK("parallel", 1'b1, parallel_bridge_output)
    `CHK("frame_select", 1'b1, frame_select)
    `CHK("sample_rate", AMP_FS_96K, sample_rate)
    amp_i2c_host_model_i.read_reg(dev_addr, `AMP_REG_FAULT_STATUS, rd, acks);
    `CHK("acks", 3'b111, acks)
    `CHK("fault status", 8'h00, rd)
    end_of_test();
  end
endmodule : testbench
